//--- rtl/csf_defs.svh
`ifndef CSF_DEFS_SVH
`define CSF_DEFS_SVH
`define CSF_BLK_BYTES 8'h10
`define CSF_MAX_CF 8'h80
`define CSF_AAD_PFX 8'h02
`define CSF_LFIELD 3'h1
`define CSF_MIC_LEN1 5'h04
`define CSF_MIC_LEN2 5'h08
`define CSF_MIC_LEN3 5'h10
`endif

//--- rtl/csf_pkg.sv
`default_nettype none
package csf_pkg;
    typedef enum logic [3:0] {S_IDLE, S_KEY, S_NONCE, S_AAD, S_PAY, S_S0, S_TAG, S_CWAIT, S_FIN} csf_state_e;
    // byte 0 is the first byte in memory and the most significant byte on the cipher port
    typedef logic [0:15][7:0] csf_blk_t;
endpackage : csf_pkg
`default_nettype wire

//--- rtl/csf_ccm_engine.sv
`include "csf_defs.svh"
`default_nettype none
// Overview of operation
// R1: encrypt authenticates F header bytes at A, then encrypts C bytes at A+F
// R2: key read from 16*K, counter block read from 16*N
// R3: zero destination means output goes to A+F, overwriting the payload
// R4: encrypt writes C ciphertext bytes then 0, 4, 8 or 16 tag bytes
// R5: priority operand zero selects the low slot, one the high slot
// R6: instruction at an already busy priority raises operand conflict
// R7: C plus F above 128 raises operand conflict
// R8: finish event of the instruction's priority fires on success or failure
// R9: decrypt authenticates header at A, decrypts C bytes at A+F to destination
// R10: host should give a zero destination so plaintext overwrites ciphertext
// R11: decrypt compares the encrypted tag against the stored tag at A+C+F
// R12: verify result lands in the high or low result bit by priority
// R13: out-of-range addresses raise address exception with no memory access
module csf_ccm_engine #(
    parameter int RAM_BYTES = 768
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic cmd_decrypt,
    input wire logic cmd_prio,
    input wire logic [7:0] cmd_key,
    input wire logic [7:0] cmd_nonce,
    input wire logic [6:0] cmd_len_c,
    input wire logic [6:0] cmd_len_f,
    input wire logic [11:0] cmd_addr_a,
    input wire logic [11:0] cmd_dest_e,
    input wire logic [1:0] cmd_mic_m,
    output logic [11:0] ram_addr,
    output logic ram_rd,
    output logic ram_wr,
    output logic [7:0] ram_wdata,
    input wire logic [7:0] ram_rdata,
    output logic aes_req_valid,
    input wire logic aes_req_ready,
    output logic [127:0] aes_key,
    output logic [127:0] aes_in,
    input wire logic aes_out_valid,
    input wire logic [127:0] aes_out,
    output logic busy_low,
    output logic busy_high,
    output logic operand_conflict_exception,
    output logic address_range_exception,
    output logic low_prio_finish_event,
    output logic high_prio_finish_event,
    output logic high_prio_verify_result,
    output logic low_prio_verify_result
);
    localparam logic [13:0] RAM_END = 14'(RAM_BYTES);

    function automatic logic [4:0] mic_len(input logic [1:0] m);
        logic [4:0] l;
        l = 5'h00;
        unique case (m)
            2'h0: l = 5'h00;
            2'h1: l = `CSF_MIC_LEN1;
            2'h2: l = `CSF_MIC_LEN2;
            2'h3: l = `CSF_MIC_LEN3;
        endcase
        return l;
    endfunction : mic_len

    function automatic csf_pkg::csf_blk_t ctr_blk(input csf_pkg::csf_blk_t b, input logic [7:0] i);
        csf_pkg::csf_blk_t r;
        r = b;
        r[14] = 8'h00;
        r[15] = i;
        return r;
    endfunction : ctr_blk

    csf_pkg::csf_state_e st_r, ret_r;
    logic [1:0] busy_r, pend_r, ph_r;
    logic slot_dec_r [2];
    logic [7:0] slot_k_r [2];
    logic [7:0] slot_n_r [2];
    logic [6:0] slot_c_r [2];
    logic [6:0] slot_f_r [2];
    logic [11:0] slot_a_r [2];
    logic [11:0] slot_e_r [2];
    logic [1:0] slot_m_r [2];
    logic dec_r, prio_r, ks_ok_r, to_mac_r, fail_r, err_r;
    logic [7:0] k_r, n_r, j_r;
    logic [6:0] c_r, f_r;
    logic [11:0] a_r, d_r;
    logic [4:0] mlen_r;
    csf_pkg::csf_blk_t key_r, ctr_r, mac_r, ks_r, ain_r, b0;
    logic [11:0] ram_addr_r;
    logic ram_rd_r, ram_wr_r, areq_r, conf_r, aerr_r, lfin_r, hfin_r, hres_r, lres_r;
    logic [7:0] ram_wdata_r;

    // instruction intake
    wire logic [7:0] sum_cf = {1'b0, cmd_len_c} + {1'b0, cmd_len_f};
    wire logic too_long = sum_cf > `CSF_MAX_CF; // [R7]
    wire logic conflict = busy_r[cmd_prio] || too_long; // [R6] [R7]
    wire logic accept = cmd_valid && !conflict;

    // slot selection, high priority first
    wire logic sp = pend_r[1];
    wire logic start_go = (st_r == csf_pkg::S_IDLE) && (pend_r != 2'h0);
    wire logic fin_go = st_r == csf_pkg::S_FIN;
    wire logic sel_dec = slot_dec_r[sp];
    wire logic [4:0] sel_mlen = mic_len(slot_m_r[sp]);
    wire logic [11:0] sel_dst = (slot_e_r[sp] == 12'h000) ?
        slot_a_r[sp] + {5'h00, slot_f_r[sp]} : slot_e_r[sp]; // [R3]
    wire logic [13:0] src_end = {2'h0, slot_a_r[sp]} + {7'h00, slot_f_r[sp]} + {7'h00, slot_c_r[sp]}
        + (sel_dec ? {9'h000, sel_mlen} : 14'h0000);
    wire logic [13:0] dst_end = {2'h0, sel_dst} + {7'h00, slot_c_r[sp]}
        + (sel_dec ? 14'h0000 : {9'h000, sel_mlen});
    wire logic [13:0] key_end = {2'h0, slot_k_r[sp], 4'h0} + 14'h0010;
    wire logic [13:0] non_end = {2'h0, slot_n_r[sp], 4'h0} + 14'h0010;
    wire logic addr_bad = (src_end > RAM_END) || (dst_end > RAM_END)
        || (key_end > RAM_END) || (non_end > RAM_END); // [R13]

    // datapath addresses and byte values
    wire logic [11:0] key_addr = {k_r, j_r[3:0]}; // [R2]
    wire logic [11:0] non_addr = {n_r, j_r[3:0]}; // [R2]
    wire logic [11:0] aad_addr = a_r + {4'h0, j_r} - {4'h0, `CSF_AAD_PFX};
    wire logic [11:0] src_addr = a_r + {5'h00, f_r} + {4'h0, j_r}; // [R1] [R9]
    wire logic [11:0] dst_addr = d_r + {4'h0, j_r};
    wire logic [11:0] tag_src = src_addr + {5'h00, c_r}; // [R11]
    wire logic [11:0] tag_dst = dst_addr + {5'h00, c_r}; // [R4]
    wire logic [7:0] nj = j_r + 8'h01;
    wire logic [7:0] aad_n = {1'b0, f_r} + `CSF_AAD_PFX;
    wire logic [7:0] aad_byte = (j_r == 8'h00) ? 8'h00 : (j_r == 8'h01) ? {1'b0, f_r} : ram_rdata;
    wire logic [7:0] pay_out = ram_rdata ^ ks_r[j_r[3:0]];
    wire logic [7:0] pay_plain = dec_r ? pay_out : ram_rdata;
    wire logic [7:0] tag_byte = mac_r[j_r[3:0]] ^ ks_r[j_r[3:0]];
    wire logic need_ks = (j_r[3:0] == 4'h0) && !ks_ok_r;
    wire logic [2:0] mfield = (mlen_r == 5'h00) ? 3'h0 : 3'((mlen_r - 5'h02) >> 1);

    always_comb
    begin
        b0 = ctr_r;
        b0[0] = {1'b0, f_r != 7'h00, mfield, `CSF_LFIELD};
        b0[14] = 8'h00;
        b0[15] = {1'b0, c_r};
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy_r <= 2'h0;
            pend_r <= 2'h0;
            conf_r <= 1'b0;
        end
        else
        begin
            conf_r <= cmd_valid && conflict; // [R6] [R7]
            busy_r <= (busy_r & ~({1'b0, fin_go} << prio_r)) | ({1'b0, accept} << cmd_prio); // [R5]
            pend_r <= (pend_r & ~({1'b0, start_go} << sp)) | ({1'b0, accept} << cmd_prio); // [R5]
        end
    end

    // slot contents need no reset: only read while the slot is pending
    always_ff @(posedge sys_clk)
    begin
        if (accept)
        begin
            slot_dec_r[cmd_prio] <= cmd_decrypt;
            slot_k_r[cmd_prio] <= cmd_key;
            slot_n_r[cmd_prio] <= cmd_nonce;
            slot_c_r[cmd_prio] <= cmd_len_c;
            slot_f_r[cmd_prio] <= cmd_len_f;
            slot_a_r[cmd_prio] <= cmd_addr_a;
            slot_e_r[cmd_prio] <= cmd_dest_e;
            slot_m_r[cmd_prio] <= cmd_mic_m;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= csf_pkg::S_IDLE;
            ret_r <= csf_pkg::S_IDLE;
            ph_r <= 2'h0;
            {dec_r, prio_r, ks_ok_r, to_mac_r, fail_r, err_r} <= 6'h00;
            {k_r, n_r, j_r} <= 24'h000000;
            {c_r, f_r, mlen_r} <= 19'h00000;
            {a_r, d_r, ram_addr_r} <= 36'h000000000;
            {key_r, ctr_r, mac_r, ks_r, ain_r} <= '0;
            {ram_rd_r, ram_wr_r, areq_r, aerr_r, lfin_r, hfin_r, hres_r, lres_r} <= 8'h00;
            ram_wdata_r <= 8'h00;
        end
        else
        begin
            ram_rd_r <= 1'b0;
            ram_wr_r <= 1'b0;
            aerr_r <= 1'b0;
            lfin_r <= 1'b0;
            hfin_r <= 1'b0;
            unique case (st_r)
                csf_pkg::S_IDLE:
                    if (start_go)
                    begin
                        {dec_r, prio_r, k_r, n_r} <= {sel_dec, sp, slot_k_r[sp], slot_n_r[sp]};
                        {c_r, f_r, a_r, d_r} <= {slot_c_r[sp], slot_f_r[sp], slot_a_r[sp], sel_dst};
                        mlen_r <= sel_mlen; // [R4] [R11]
                        {j_r, ph_r, ks_ok_r, fail_r, err_r} <= {8'h00, 2'h0, 1'b0, 1'b0, addr_bad};
                        mac_r <= '0;
                        aerr_r <= addr_bad; // [R13]
                        st_r <= addr_bad ? csf_pkg::S_FIN : csf_pkg::S_KEY; // [R13]
                    end
                csf_pkg::S_KEY, csf_pkg::S_NONCE:
                    if (ph_r == 2'h0)
                    begin
                        ram_addr_r <= (st_r == csf_pkg::S_KEY) ? key_addr : non_addr; // [R2]
                        ram_rd_r <= 1'b1;
                        ph_r <= 2'h1;
                    end
                    else if (ph_r == 2'h1)
                        ph_r <= 2'h2;
                    else
                    begin
                        ph_r <= 2'h0;
                        j_r <= (j_r[3:0] == 4'hF) ? 8'h00 : nj;
                        if (st_r == csf_pkg::S_KEY)
                        begin
                            key_r[j_r[3:0]] <= ram_rdata;
                            if (j_r[3:0] == 4'hF)
                                st_r <= csf_pkg::S_NONCE;
                        end
                        else
                        begin
                            ctr_r[j_r[3:0]] <= ram_rdata;
                            if (j_r[3:0] == 4'hF)
                            begin
                                ain_r <= b0;
                                to_mac_r <= 1'b1;
                                areq_r <= 1'b1;
                                st_r <= csf_pkg::S_CWAIT;
                                ret_r <= (f_r != 7'h00) ? csf_pkg::S_AAD :
                                    (c_r != 7'h00) ? csf_pkg::S_PAY : csf_pkg::S_S0;
                            end
                        end
                    end
                csf_pkg::S_AAD: // [R1] [R9]
                    if (ph_r == 2'h0)
                    begin
                        ram_addr_r <= aad_addr;
                        ram_rd_r <= j_r >= `CSF_AAD_PFX;
                        ph_r <= (j_r >= `CSF_AAD_PFX) ? 2'h1 : 2'h2;
                    end
                    else if (ph_r == 2'h1)
                        ph_r <= 2'h2;
                    else
                    begin
                        ph_r <= 2'h0;
                        j_r <= (nj == aad_n) ? 8'h00 : nj;
                        if (j_r[3:0] == 4'hF || nj == aad_n)
                        begin
                            ain_r <= mac_r ^ ({aad_byte, 120'h0} >> {j_r[3:0], 3'h0});
                            to_mac_r <= 1'b1;
                            areq_r <= 1'b1;
                            st_r <= csf_pkg::S_CWAIT;
                            ret_r <= (nj != aad_n) ? csf_pkg::S_AAD :
                                (c_r != 7'h00) ? csf_pkg::S_PAY : csf_pkg::S_S0;
                        end
                        else
                            mac_r[j_r[3:0]] <= mac_r[j_r[3:0]] ^ aad_byte;
                    end
                csf_pkg::S_PAY: // [R1] [R9]
                    if (ph_r == 2'h0)
                    begin
                        if (need_ks)
                        begin
                            ain_r <= ctr_blk(ctr_r, {1'b0, j_r[6:4]} + 8'h01);
                            to_mac_r <= 1'b0;
                            areq_r <= 1'b1;
                            ks_ok_r <= 1'b1;
                            st_r <= csf_pkg::S_CWAIT;
                            ret_r <= csf_pkg::S_PAY;
                        end
                        else
                        begin
                            ram_addr_r <= src_addr;
                            ram_rd_r <= 1'b1;
                            ph_r <= 2'h1;
                        end
                    end
                    else if (ph_r == 2'h1)
                        ph_r <= 2'h2;
                    else
                    begin
                        ph_r <= 2'h0;
                        ram_addr_r <= dst_addr; // [R3]
                        ram_wr_r <= 1'b1;
                        ram_wdata_r <= pay_out;
                        j_r <= (nj == {1'b0, c_r}) ? 8'h00 : nj;
                        ks_ok_r <= ks_ok_r && (nj[3:0] != 4'h0);
                        if (nj[3:0] == 4'h0 || nj == {1'b0, c_r})
                        begin
                            ain_r <= mac_r ^ ({pay_plain, 120'h0} >> {j_r[3:0], 3'h0});
                            to_mac_r <= 1'b1;
                            areq_r <= 1'b1;
                            st_r <= csf_pkg::S_CWAIT;
                            ret_r <= (nj == {1'b0, c_r}) ? csf_pkg::S_S0 : csf_pkg::S_PAY;
                        end
                        else
                            mac_r[j_r[3:0]] <= mac_r[j_r[3:0]] ^ pay_plain;
                    end
                csf_pkg::S_S0:
                begin
                    ain_r <= ctr_blk(ctr_r, 8'h00);
                    to_mac_r <= 1'b0;
                    areq_r <= 1'b1;
                    j_r <= 8'h00;
                    st_r <= csf_pkg::S_CWAIT;
                    ret_r <= csf_pkg::S_TAG;
                end
                csf_pkg::S_TAG:
                    if (j_r == {3'h0, mlen_r})
                        st_r <= csf_pkg::S_FIN;
                    else if (!dec_r)
                    begin
                        ram_addr_r <= tag_dst; // [R4]
                        ram_wr_r <= 1'b1;
                        ram_wdata_r <= tag_byte;
                        j_r <= nj;
                    end
                    else if (ph_r == 2'h0)
                    begin
                        ram_addr_r <= tag_src; // [R11]
                        ram_rd_r <= 1'b1;
                        ph_r <= 2'h1;
                    end
                    else if (ph_r == 2'h1)
                        ph_r <= 2'h2;
                    else
                    begin
                        ph_r <= 2'h0;
                        fail_r <= fail_r || (ram_rdata != tag_byte); // [R11]
                        j_r <= nj;
                    end
                csf_pkg::S_CWAIT:
                    // the result is taken only after the request has been accepted
                    if (areq_r && aes_req_ready)
                        areq_r <= 1'b0;
                    else if (!areq_r && aes_out_valid)
                    begin
                        if (to_mac_r)
                            mac_r <= aes_out;
                        else
                            ks_r <= aes_out;
                        st_r <= ret_r;
                    end
                csf_pkg::S_FIN:
                begin
                    lfin_r <= !prio_r; // [R8]
                    hfin_r <= prio_r; // [R8]
                    if (dec_r && !err_r && prio_r)
                        hres_r <= !fail_r; // [R12]
                    if (dec_r && !err_r && !prio_r)
                        lres_r <= !fail_r; // [R12]
                    st_r <= csf_pkg::S_IDLE;
                end
            endcase
        end
    end

    assign ram_addr = ram_addr_r;
    assign ram_rd = ram_rd_r;
    assign ram_wr = ram_wr_r;
    assign ram_wdata = ram_wdata_r;
    assign aes_req_valid = areq_r;
    assign aes_key = key_r;
    assign aes_in = ain_r;
    assign busy_low = busy_r[0];
    assign busy_high = busy_r[1];
    assign operand_conflict_exception = conf_r;
    assign address_range_exception = aerr_r;
    assign low_prio_finish_event = lfin_r;
    assign high_prio_finish_event = hfin_r;
    assign high_prio_verify_result = hres_r;
    assign low_prio_verify_result = lres_r;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    logic [4:0] tag_wr_cnt;
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            tag_wr_cnt <= 5'h00;
        else if (start_go)
            tag_wr_cnt <= 5'h00;
        // a tag write shows on the port one cycle after it is issued, still inside the tag state
        else if (st_r == csf_pkg::S_TAG && ram_wr_r && !dec_r)
            tag_wr_cnt <= tag_wr_cnt + 5'h01;
    end

    sequence no_access_s;
        (!ram_rd && !ram_wr) [*2];
    endsequence
    sequence fin_low_s;
        low_prio_finish_event && !high_prio_finish_event;
    endsequence

    busy_conflict_a: assert property (cmd_valid && busy_r[cmd_prio] |=> operand_conflict_exception) // [R6]
        else $error("busy priority did not raise conflict");
    // a finish in the same cycle may clear a busy bit, so only a newly set bit is an error
    length_conflict_a: assert property (cmd_valid && too_long // [R7]
        |=> operand_conflict_exception && ((busy_r & ~$past(busy_r)) == 2'h0))
        else $error("oversize instruction not refused");
    slot_select_a: assert property (accept |=> busy_r[$past(cmd_prio)] && pend_r[$past(cmd_prio)]) // [R5]
        else $error("instruction not placed in its priority slot");
    finish_prio_a: assert property (fin_go && !prio_r |=> fin_low_s) // [R8]
        else $error("wrong finish event");
    key_fetch_a: assert property (st_r == csf_pkg::S_KEY && ph_r == 2'h0 // [R2]
        |=> ram_rd && ram_addr == {$past(k_r), $past(j_r[3:0])})
        else $error("key fetched from wrong address");
    dest_zero_a: assert property (start_go && slot_e_r[sp] == 12'h000 // [R3]
        |=> d_r == $past(slot_a_r[sp]) + {5'h00, $past(slot_f_r[sp])})
        else $error("zero destination not mapped to payload");
    tag_count_a: assert property (fin_go && !dec_r && !err_r |-> tag_wr_cnt == mlen_r) // [R4]
        else $error("tag length mismatch");
    verify_low_a: assert property (fin_go && dec_r && !err_r && !prio_r // [R12]
        |=> low_prio_verify_result == !$past(fail_r))
        else $error("low verify result not recorded");
    range_block_a: assert property (start_go && addr_bad |=> address_range_exception ##0 no_access_s) // [R13]
        else $error("bad address accessed memory");
    pay_src_a: assert property (st_r == csf_pkg::S_PAY && ph_r == 2'h0 && !need_ks // [R1]
        |=> ram_rd && ram_addr == $past(src_addr) ##2 ram_wr)
        else $error("payload byte sequence broken");
    tag_cmp_a: assert property (st_r == csf_pkg::S_TAG && dec_r && ph_r == 2'h0 && j_r != {3'h0, mlen_r} // [R11]
        |=> ram_rd && ram_addr == $past(tag_src))
        else $error("stored tag read from wrong address");
endmodule : csf_ccm_engine
`default_nettype wire

//--- dv/csf_far_model.sv
`default_nettype none
// byte ram plus a stand-in block cipher (out = in ^ key), enough to check data paths
module csf_far_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic [11:0] ram_addr,
    input wire logic ram_rd,
    input wire logic ram_wr,
    input wire logic [7:0] ram_wdata,
    output logic [7:0] ram_rdata,
    input wire logic aes_req_valid,
    output logic aes_req_ready,
    input wire logic [127:0] aes_key,
    input wire logic [127:0] aes_in,
    output logic aes_out_valid,
    output logic [127:0] aes_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:767];
    logic [127:0] res_r;
    logic pend_r;
    logic gap_r;
    int wait_r;
    assign aes_req_ready = !pend_r && (!slow || gap_r);
    always @(posedge sys_clk)
    begin
        // stale read data is scrambled so nothing can lean on it
        ram_rdata <= ram_rd ? mem[ram_addr] : ~ram_rdata;
        if (ram_wr)
            mem[ram_addr] <= ram_wdata;
    end
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pend_r <= 1'b0;
            gap_r <= 1'b0;
            wait_r <= 0;
            aes_out_valid <= 1'b0;
            aes_out <= 128'h0;
        end
        else
        begin
            gap_r <= ~gap_r;
            aes_out_valid <= 1'b0;
            aes_out <= ~aes_out;
            if (aes_req_valid && aes_req_ready)
            begin
                res_r <= aes_in ^ aes_key;
                pend_r <= 1'b1;
                wait_r <= slow ? 6 : 1;
            end
            else if (pend_r && wait_r > 1)
                wait_r <= wait_r - 1;
            else if (pend_r)
            begin
                pend_r <= 1'b0;
                aes_out_valid <= 1'b1;
                aes_out <= res_r;
            end
        end
    end
endmodule : csf_far_model
`default_nettype wire

//--- dv/csf_ccm_engine_test.sv
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module csf_ccm_engine_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, rst_n = 0, cmd_valid = 0, cmd_decrypt = 0, cmd_prio = 0, slow = 0;
    logic [7:0] cmd_key = 8'h02, cmd_nonce = 8'h03;
    logic [6:0] cmd_len_c = 7'h00, cmd_len_f = 7'h00;
    logic [11:0] cmd_addr_a = 12'h000, cmd_dest_e = 12'h000, ram_addr;
    logic [1:0] cmd_mic_m = 2'h0;
    logic ram_rd, ram_wr, aes_req_valid, aes_req_ready, aes_out_valid, busy_low, busy_high;
    logic [7:0] ram_wdata, ram_rdata;
    logic [127:0] aes_key, aes_in, aes_out;
    logic oc_exc, ar_exc, lo_fin, hi_fin, hi_res, lo_res;
    int error_cnt = 0, checked = 0, n_wr, n_rd, n_lo, n_hi, n_conf, n_addr;
    csf_ccm_engine csf_ccm_engine_inst (.sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
        .cmd_decrypt(cmd_decrypt), .cmd_prio(cmd_prio), .cmd_key(cmd_key), .cmd_nonce(cmd_nonce),
        .cmd_len_c(cmd_len_c), .cmd_len_f(cmd_len_f), .cmd_addr_a(cmd_addr_a), .cmd_dest_e(cmd_dest_e),
        .cmd_mic_m(cmd_mic_m), .ram_addr(ram_addr), .ram_rd(ram_rd), .ram_wr(ram_wr), .ram_wdata(ram_wdata),
        .ram_rdata(ram_rdata), .aes_req_valid(aes_req_valid), .aes_req_ready(aes_req_ready), .aes_key(aes_key),
        .aes_in(aes_in), .aes_out_valid(aes_out_valid), .aes_out(aes_out), .busy_low(busy_low),
        .busy_high(busy_high), .operand_conflict_exception(oc_exc), .address_range_exception(ar_exc),
        .low_prio_finish_event(lo_fin), .high_prio_finish_event(hi_fin), .high_prio_verify_result(hi_res),
        .low_prio_verify_result(lo_res));
    csf_far_model csf_far_model_inst (.sys_clk(sys_clk), .rst_n(rst_n), .slow(slow), .ram_addr(ram_addr),
        .ram_rd(ram_rd), .ram_wr(ram_wr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata),
        .aes_req_valid(aes_req_valid), .aes_req_ready(aes_req_ready), .aes_key(aes_key), .aes_in(aes_in),
        .aes_out_valid(aes_out_valid), .aes_out(aes_out));
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        if (ram_wr === 1'b1) n_wr++;
        if (ram_rd === 1'b1) n_rd++;
        if (lo_fin === 1'b1) n_lo++;
        if (hi_fin === 1'b1) n_hi++;
        if (oc_exc === 1'b1) n_conf++;
        if (ar_exc === 1'b1) n_addr++;
    end
    task automatic give_verdict();
        if (error_cnt == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict
    function automatic logic [7:0] rd(int a);
        return csf_far_model_inst.mem[a];
    endfunction : rd
    // keystream byte j of the payload: key byte ^ counter block i = j/16+1
    function automatic logic [7:0] ks(int j);
        int b;
        logic [7:0] c;
        b = j % 16;
        c = (b == 14) ? 8'h00 : (b == 15) ? 8'(j / 16 + 1) : 8'h50 + 8'(b);
        return (8'hA0 + 8'(b)) ^ c;
    endfunction : ks
    task automatic fill();
        for (int i = 0; i < 16; i++)
        begin
            csf_far_model_inst.mem[32 + i] = 8'hA0 + 8'(i);
            csf_far_model_inst.mem[48 + i] = 8'h50 + 8'(i);
        end
        for (int i = 0; i < 256; i++)
            csf_far_model_inst.mem[256 + i] = 8'(i) ^ 8'h3C;
        {n_wr, n_rd, n_lo, n_hi, n_conf, n_addr} = '0;
    endtask : fill
    task automatic issue(logic d, logic p, int c, int f, logic [11:0] a, logic [11:0] e, logic [1:0] m, bit wt);
        int i;
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd_decrypt <= d;
        cmd_prio <= p;
        cmd_len_c <= 7'(c);
        cmd_len_f <= 7'(f);
        cmd_addr_a <= a;
        cmd_dest_e <= e;
        cmd_mic_m <= m;
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        @(posedge sys_clk);
        #1;
        for (i = 0; wt && i < 20000 && (busy_low !== 1'b0 || busy_high !== 1'b0); i++)
            @(posedge sys_clk);
        if (i == 20000)
        begin
            error_cnt++;
            give_verdict();
        end
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : issue
    task automatic s_round_trip();
        fill();
        issue(0, 0, 20, 4, 12'h100, 12'h000, 2, 1);
        `CHK("writes", 28, n_wr)
        `CHK("low done", 1, n_lo)
        `CHK("high done", 0, n_hi)
        `CHK("header", 8'h3C, rd(256))
        for (int j = 0; j < 20; j++)
            `CHK("cipher", 8'(j + 4) ^ 8'h3C ^ ks(j), rd(260 + j))
        slow <= 1'b1;
        issue(1, 1, 20, 4, 12'h100, 12'h000, 2, 1);
        `CHK("high pass", 1'b1, hi_res)
        `CHK("high done", 1, n_hi)
        for (int j = 0; j < 20; j++)
            `CHK("plain", 8'(j + 4) ^ 8'h3C, rd(260 + j))
        // first pass keeps the tag, second flips one tag bit: the result bit must go up, then down
        for (int k = 0; k < 2; k++)
        begin
            issue(0, 0, 20, 4, 12'h100, 12'h000, 2, 1);
            csf_far_model_inst.mem[280] = rd(280) ^ 8'(k);
            issue(1, 0, 20, 4, 12'h100, 12'h000, 2, 1);
            `CHK("low result", 1'(k == 0), lo_res)
        end
        slow <= 1'b0;
        `CHK("high kept", 1'b1, hi_res)
    endtask : s_round_trip
    task automatic s_tag_len();
        for (int m = 0; m < 4; m++)
        begin
            fill();
            // the untagged run also goes without a header
            issue(0, 0, 20, (m == 0) ? 0 : 4, 12'h100, 12'h200, 2'(m), 1);
            `CHK("writes", 20 + ((m == 0) ? 0 : 4 << (m - 1)), n_wr)
            `CHK("dest", ((m == 0) ? 8'h3C : 8'h38) ^ ks(0), rd(512))
        end
    endtask : s_tag_len
    task automatic s_conflict();
        fill();
        issue(0, 0, 20, 4, 12'h100, 12'h200, 1, 0);
        issue(0, 0, 20, 4, 12'h100, 12'h200, 1, 0);
        `CHK("busy slot", 1, n_conf)
        issue(0, 1, 100, 29, 12'h100, 12'h000, 0, 0);
        `CHK("oversize", 2, n_conf)
        issue(0, 1, 100, 28, 12'h100, 12'h000, 0, 1);
        `CHK("limit ok", 2, n_conf)
        `CHK("high ran", 1, n_hi)
        `CHK("low ran", 1, n_lo)
    endtask : s_conflict
    task automatic s_addr();
        fill();
        issue(1, 1, 40, 0, 12'h2F0, 12'h000, 3, 1);
        `CHK("addr exc", 1, n_addr)
        `CHK("no reads", 0, n_rd + n_wr)
        `CHK("done", 1, n_hi)
    endtask : s_addr
    initial
    begin
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        s_round_trip();
        s_tag_len();
        s_conflict();
        s_addr();
        give_verdict();
    end
endmodule : csf_ccm_engine_test
`default_nettype wire
